// file: osc_ref_clock_ctrl.sv
// Internal oscillator control, mid-frequency clocks, status and reference clock output.
// Assumes oscillator activity arrives as single-cycle edge ticks synchronous to CLOCK.
// What this block does
// - In internal oscillator mode, free the input pin; output pin is GPIO or clock.
// - Configuration clock-out enable picks GPIO or clock output on the output pin.
// - Two independent internal oscillators, each usable as system clock.
// - Fast oscillator frequency set by select register and trimmed by tuning register.
// - Slow oscillator supplies a fixed 31 kHz clock.
// - Reset oscillator codes 110 or 000 start the fast oscillator at 1 or 64 MHz.
// - Writing the new oscillator field requests a system clock source switch.
// - Four-bit frequency field sets the fast oscillator frequency.
// - Four-bit post divider divides the fast oscillator from 1:1 to 1:512.
// - Mid block derives steady 500 kHz and 31.25 kHz from any fast frequency.
// - Mid-frequency clocks never drive the system clock, only peripherals.
// - Slow oscillator clocks power-up timer, watchdog and fail-safe monitor.
// - Status register reports read-only ready flags; only the fast and mid flags also need the fast oscillator enabled.
// - Reference source: system, fast, slow, 500 kHz, secondary; others unimplemented.
// - Enabling the reference output starts it without a glitch.
// - Disabling the reference output stops it at once.
// - Reference divider offers divide by 1, 2, 4, 8, 16, 32, 64, 128.
// - Duty selects 0, 25, 50 or 75 percent high unless undivided.
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module osc_ref_clock_ctrl
  import osc_ref_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  // Register port
  input  wire logic [11:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  // Configuration words
  input  wire logic [2:0]  RESET_OSC_SELECT,
  input  wire logic        CLOCK_OUT_PIN_ENABLE,
  // Oscillator ticks and ready levels
  input  wire logic        HS_OSC_TICK,
  input  wire logic        HS_OSC_READY,
  input  wire logic        LS_OSC_TICK,
  input  wire logic        LS_OSC_READY,
  input  wire logic        EXT_SYS_TICK,
  input  wire logic        SEC_OSC_TICK,
  input  wire logic        EXTERNAL_READY,
  input  wire logic        SECONDARY_READY,
  input  wire logic        ADC_OSC_OK,
  input  wire logic        PLL_LOCK_READY,
  // Fast oscillator control
  output logic             HS_OSC_EN,
  output logic      [3:0]  HS_FREQ,
  output logic      [5:0]  HS_TUNE,
  // System clock
  output logic      [2:0]  SYS_SRC,
  output logic             SYS_SWITCH_REQ,
  output logic             SYS_TICK,
  // Peripheral clocks
  output logic             MF_500K_TICK,
  output logic             MF_31K_TICK,
  output logic             LS_TIMER_TICK,
  // Oscillator pins
  output logic             IN_PIN_GPIO,
  output logic             OUT_PIN_GPIO,
  output logic             OUT_PIN_O,
  output logic             OUT_PIN_OE,
  // Reference clock
  output logic             REF_CLK_OUT
);
  logic [2:0] sys_src_r,  sys_src_nxt;
  logic       sw_req_r,   sw_req_nxt;
  logic [3:0] hs_post_prescale_r,     hs_post_prescale_nxt;
  logic [3:0] hs_freq_r,  hs_freq_nxt;
  logic [5:0] hs_tune_r,  hs_tune_nxt;
  logic [7:0] ref_ctrl_r, ref_ctrl_nxt;
  logic [2:0] ref_src_r,  ref_src_nxt;
  logic [7:0] status_r,   status_nxt;
  logic [7:0] rdata_r,    rdata_nxt;
  logic       hs_en_r,    hs_en_nxt;
  logic       sys_tick_r, sys_tick_nxt;
  logic       ls_tick_r,  ls_tick_nxt;
  logic [1:0] co_cnt_r,   co_cnt_nxt;
  logic       pin_o_r,    pin_o_nxt;
  logic       in_gpio_r,  in_gpio_nxt;
  logic       out_gpio_r, out_gpio_nxt;
  logic       out_oe_r,   out_oe_nxt;
  logic       sys_is_hs;
  logic       sys_is_int;
  logic       hs_tick;
  logic       hs_div_tick;
  logic       mf_hi_tick;
  logic       mf_lo_tick;
  logic       ref_tick;
  logic [9:0] hs_post_prescale_val;
  logic       ref_en;

  assign ref_en = ref_ctrl_r[REF_EN_BIT];

  // Register file and status.
  always_comb begin
    sys_src_nxt  = sys_src_r;
    sw_req_nxt   = 1'b0;
    hs_post_prescale_nxt     = hs_post_prescale_r;
    hs_freq_nxt  = hs_freq_r;
    hs_tune_nxt  = hs_tune_r;
    ref_ctrl_nxt = ref_ctrl_r;
    ref_src_nxt  = ref_src_r;
    if (WR) begin
      case (ADDR)
        REG_OSC_CTRL: begin
          sys_src_nxt = WDATA[NEW_OSC_SELECT_LSB +: 3];
          sw_req_nxt  = 1'b1;
          hs_post_prescale_nxt    = WDATA[HS_POST_PRESCALE_LSB +: 4];
        end
        REG_HS_FREQ:  hs_freq_nxt  = WDATA[3:0];
        REG_HS_TUNE:  hs_tune_nxt  = WDATA[5:0];
        REG_REF_CTRL: ref_ctrl_nxt = WDATA & 8'h9f;
        REG_REF_SRC:  ref_src_nxt  = WDATA[2:0];
        default: begin
        end
      endcase
    end
    status_nxt         = 8'h00;
    status_nxt[ST_EXT] = EXTERNAL_READY;
    status_nxt[ST_HS]  = hs_en_r & HS_OSC_READY;
    status_nxt[ST_MF]  = hs_en_r & HS_OSC_READY;
    status_nxt[ST_LS]  = LS_OSC_READY;
    status_nxt[ST_SEC] = SECONDARY_READY;
    status_nxt[ST_ADC] = ADC_OSC_OK;
    status_nxt[ST_PLL] = PLL_LOCK_READY;
    rdata_nxt = 8'h00;
    if (RD) begin
      case (ADDR)
        REG_OSC_CTRL:   rdata_nxt = {hs_post_prescale_r, 1'b0, sys_src_r};
        REG_HS_FREQ:    rdata_nxt = {4'h0, hs_freq_r};
        REG_HS_TUNE:    rdata_nxt = {2'h0, hs_tune_r};
        REG_OSC_STATUS: rdata_nxt = status_r;
        REG_REF_CTRL:   rdata_nxt = ref_ctrl_r;
        REG_REF_SRC:    rdata_nxt = {5'h00, ref_src_r};
        default:        rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      // The reset oscillator choice is caught from the configuration words each reset cycle.
      sys_src_r  <= RESET_OSC_SELECT;
      hs_freq_r  <= (RESET_OSC_SELECT == OSC_HS_1M) ? HS_FRQ_1M : HS_FRQ_64M;
      sw_req_r   <= 1'b0;
      hs_post_prescale_r     <= HS_POST_PRESCALE_RST;
      hs_tune_r  <= HS_TUNE_RST;
      ref_ctrl_r <= REF_CTRL_RST;
      ref_src_r  <= REF_SRC_RST;
      status_r   <= 8'h00;
      rdata_r    <= 8'h00;
    end else begin
      sys_src_r  <= sys_src_nxt;
      hs_freq_r  <= hs_freq_nxt;
      sw_req_r   <= sw_req_nxt;
      hs_post_prescale_r     <= hs_post_prescale_nxt;
      hs_tune_r  <= hs_tune_nxt;
      ref_ctrl_r <= ref_ctrl_nxt;
      ref_src_r  <= ref_src_nxt;
      status_r   <= status_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // Clock sources, system clock and pins.
  always_comb begin
    sys_is_hs  = (sys_src_r == OSC_HS_64M) || (sys_src_r == OSC_HS_1M);
    sys_is_int = sys_is_hs || (sys_src_r == OSC_LS);
    hs_en_nxt  = sys_is_hs || (ref_en && (ref_src_r == REF_SRC_HS || ref_src_r == REF_SRC_MF));
    hs_post_prescale_val   = 10'h001 << ((hs_post_prescale_r > HS_POST_PRESCALE_MAX) ? HS_POST_PRESCALE_MAX : hs_post_prescale_r);
    // Mid-frequency ticks never enter this selection.
    if (sys_is_hs) begin
      sys_tick_nxt = hs_div_tick;
    end else if (sys_src_r == OSC_LS) begin
      sys_tick_nxt = LS_OSC_TICK;
    end else begin
      sys_tick_nxt = EXT_SYS_TICK;
    end
    ls_tick_nxt = LS_OSC_TICK;
    case (ref_src_r)
      REF_SRC_SYS: ref_tick = sys_tick_r;
      REF_SRC_HS:  ref_tick = hs_tick;
      REF_SRC_LS:  ref_tick = LS_OSC_TICK;
      REF_SRC_MF:  ref_tick = mf_hi_tick;
      REF_SRC_SEC: ref_tick = SEC_OSC_TICK;
      default:     ref_tick = 1'b0;
    endcase
    // The clock output pin runs at a quarter of the system clock.
    co_cnt_nxt = sys_tick_r ? co_cnt_r + 2'h1 : co_cnt_r;
    pin_o_nxt  = (sys_tick_r && co_cnt_r == CLKOUT_EDGES) ? !pin_o_r : pin_o_r;
    in_gpio_nxt  = sys_is_int;
    out_oe_nxt   = sys_is_int && CLOCK_OUT_PIN_ENABLE;
    out_gpio_nxt = sys_is_int && !CLOCK_OUT_PIN_ENABLE;
  end

  assign hs_tick = HS_OSC_TICK & hs_en_r;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      hs_en_r    <= 1'b0;
      sys_tick_r <= 1'b0;
      ls_tick_r  <= 1'b0;
      co_cnt_r   <= 2'h0;
      pin_o_r    <= 1'b0;
      in_gpio_r  <= 1'b0;
      out_oe_r   <= 1'b0;
      out_gpio_r <= 1'b0;
    end else begin
      hs_en_r    <= hs_en_nxt;
      sys_tick_r <= sys_tick_nxt;
      ls_tick_r  <= ls_tick_nxt;
      co_cnt_r   <= co_cnt_nxt;
      pin_o_r    <= pin_o_nxt;
      in_gpio_r  <= in_gpio_nxt;
      out_oe_r   <= out_oe_nxt;
      out_gpio_r <= out_gpio_nxt;
    end
  end

  tick_divider #(.W(10)) u_post_div (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .tick_in  (hs_tick),
    .divisor  (hs_post_prescale_val),
    .tick_out (hs_div_tick)
  );

  // The ratio follows the frequency field so the mid clocks keep their rate.
  tick_divider #(.W(8)) u_mf_high (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .tick_in  (hs_tick),
    .divisor  (mf_ratio(hs_freq_r)),
    .tick_out (mf_hi_tick)
  );

  tick_divider #(.W(8)) u_mf_low (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .tick_in  (mf_hi_tick),
    .divisor  (MF_LOW_RATIO),
    .tick_out (mf_lo_tick)
  );

  ref_clock_out u_ref (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .en       (ref_en),
    .div      (ref_ctrl_r[REF_DIV_LSB +: 3]),
    .duty     (ref_ctrl_r[REF_DUTY_LSB +: 2]),
    .src_tick (ref_tick),
    .ref_out  (REF_CLK_OUT)
  );

  assign RDATA          = rdata_r;
  assign HS_OSC_EN      = hs_en_r;
  assign HS_FREQ        = hs_freq_r;
  assign HS_TUNE        = hs_tune_r;
  assign SYS_SRC        = sys_src_r;
  assign SYS_SWITCH_REQ = sw_req_r;
  assign SYS_TICK       = sys_tick_r;
  assign MF_500K_TICK   = mf_hi_tick;
  assign MF_31K_TICK    = mf_lo_tick;
  assign LS_TIMER_TICK  = ls_tick_r;
  assign IN_PIN_GPIO    = in_gpio_r;
  assign OUT_PIN_GPIO   = out_gpio_r;
  assign OUT_PIN_O      = pin_o_r;
  assign OUT_PIN_OE     = out_oe_r;

  property p_status_bit1;
    @(posedge CLOCK) disable iff (!RST_N) RD && ADDR == REG_OSC_STATUS |=> RDATA[1] == 1'b0;
  endproperty
  a_status_bit1: assert property (p_status_bit1) else $error("status bit 1 read as one");

  property p_hs_ready;
    @(posedge CLOCK) disable iff (!RST_N) ##1 status_r[ST_HS] == ($past(hs_en_r) & $past(HS_OSC_READY));
  endproperty
  a_hs_ready: assert property (p_hs_ready) else $error("fast ready flag does not follow enable and ready");

  property p_switch_req;
    @(posedge CLOCK) disable iff (!RST_N) WR && ADDR == REG_OSC_CTRL |=> SYS_SWITCH_REQ && SYS_SRC == $past(WDATA[2:0]);
  endproperty
  a_switch_req: assert property (p_switch_req) else $error("oscillator write did not request a switch");

  property p_reset_freq;
    @(posedge CLOCK) $rose(RST_N) && $past(RESET_OSC_SELECT) == OSC_HS_1M |-> HS_FREQ == HS_FRQ_1M;
  endproperty
  a_reset_freq: assert property (p_reset_freq) else $error("reset oscillator code did not set 1 MHz");

  property p_mf_chain;
    @(posedge CLOCK) disable iff (!RST_N) MF_31K_TICK |-> $past(MF_500K_TICK);
  endproperty
  a_mf_chain: assert property (p_mf_chain) else $error("low mid clock not derived from 500 kHz clock");

  property p_clkout_pin;
    @(posedge CLOCK) disable iff (!RST_N) sys_is_int && CLOCK_OUT_PIN_ENABLE |=> OUT_PIN_OE && !OUT_PIN_GPIO;
  endproperty
  a_clkout_pin: assert property (p_clkout_pin) else $error("clock output pin not driven");

endmodule : osc_ref_clock_ctrl
`default_nettype wire

// file: osc_ref_clock_ctrl_tb_top.sv
// Self-checking bench for the oscillator control and reference clock block.
// Assumes the package and design modules are compiled first; oscillator ticks are made here.
`timescale 1ns/10ps
`default_nettype none
module osc_ref_clock_ctrl_tb_top
  import osc_ref_pkg::*;
;
  logic        CLOCK = 1'b0;
  logic        RST_N = 1'b0;
  logic [11:0] ADDR = 12'h000;
  logic [7:0]  WDATA = 8'h00;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [2:0]  RESET_OSC_SELECT = 3'h6;
  logic        CLOCK_OUT_PIN_ENABLE = 1'b0;
  logic        HS_OSC_TICK = 1'b0, LS_OSC_TICK = 1'b0, EXT_SYS_TICK = 1'b0, SEC_OSC_TICK = 1'b0;
  logic        HS_OSC_READY = 1'b0, LS_OSC_READY = 1'b0, EXTERNAL_READY = 1'b0;
  logic        SECONDARY_READY = 1'b0, ADC_OSC_OK = 1'b0, PLL_LOCK_READY = 1'b0;
  logic [7:0]  RDATA;
  logic [3:0]  HS_FREQ;
  logic [5:0]  HS_TUNE;
  logic [2:0]  SYS_SRC;
  logic        HS_OSC_EN, SYS_SWITCH_REQ, SYS_TICK, MF_500K_TICK, MF_31K_TICK, LS_TIMER_TICK;
  logic        IN_PIN_GPIO, OUT_PIN_GPIO, OUT_PIN_O, OUT_PIN_OE, REF_CLK_OUT;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;

  osc_ref_clock_ctrl u_osc_ref_clock_ctrl (
    .CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .RESET_OSC_SELECT(RESET_OSC_SELECT), .CLOCK_OUT_PIN_ENABLE(CLOCK_OUT_PIN_ENABLE),
    .HS_OSC_TICK(HS_OSC_TICK), .HS_OSC_READY(HS_OSC_READY), .LS_OSC_TICK(LS_OSC_TICK),
    .LS_OSC_READY(LS_OSC_READY), .EXT_SYS_TICK(EXT_SYS_TICK), .SEC_OSC_TICK(SEC_OSC_TICK),
    .EXTERNAL_READY(EXTERNAL_READY), .SECONDARY_READY(SECONDARY_READY), .ADC_OSC_OK(ADC_OSC_OK),
    .PLL_LOCK_READY(PLL_LOCK_READY), .HS_OSC_EN(HS_OSC_EN), .HS_FREQ(HS_FREQ), .HS_TUNE(HS_TUNE),
    .SYS_SRC(SYS_SRC), .SYS_SWITCH_REQ(SYS_SWITCH_REQ), .SYS_TICK(SYS_TICK),
    .MF_500K_TICK(MF_500K_TICK), .MF_31K_TICK(MF_31K_TICK), .LS_TIMER_TICK(LS_TIMER_TICK),
    .IN_PIN_GPIO(IN_PIN_GPIO), .OUT_PIN_GPIO(OUT_PIN_GPIO), .OUT_PIN_O(OUT_PIN_O),
    .OUT_PIN_OE(OUT_PIN_OE), .REF_CLK_OUT(REF_CLK_OUT)
  );

  always #5 CLOCK = ~CLOCK;

  // The fast oscillator edges every 4 cycles, so expected spacings are ratios times 4.
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    HS_OSC_TICK <= (cyc % 4 == 0);
    LS_OSC_TICK <= (cyc % 16 == 5);
    EXT_SYS_TICK <= (cyc % 8 == 2);
    SEC_OSC_TICK <= (cyc % 12 == 7);
  end

  always @(posedge CLOCK) begin
    if (cyc == 90000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd

  task automatic cycles(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : cycles

  // Cycles between the second and third pulse, so a ratio change settles first.
  task automatic gap(input int sel, output int g);
    int k;
    logic p;
    k = 0;
    g = 0;
    while (k < 3 && g < 5000) begin
      cycles(1);
      g++;
      p = (sel == 0) ? MF_500K_TICK : (sel == 1) ? MF_31K_TICK : SYS_TICK;
      if (p === 1'b1) begin
        k++;
        if (k < 3) g = 0;
      end
    end
  endtask : gap

  task automatic count_high(input int n, output int h);
    h = 0;
    repeat (n) begin
      cycles(1);
      if (REF_CLK_OUT === 1'b1) h++;
    end
  endtask : count_high

  task automatic t_reset(input logic [2:0] code, input logic cko);
    logic intl;
    intl = (code == OSC_HS_1M) || (code == OSC_HS_64M);
    @(posedge CLOCK);
    RESET_OSC_SELECT <= code;
    CLOCK_OUT_PIN_ENABLE <= cko;
    RST_N <= 1'b0;
    cycles(3);
    chk("reset freq", HS_FREQ, (code == OSC_HS_1M) ? HS_FRQ_1M : HS_FRQ_64M);
    chk("reset src", SYS_SRC, code);
    @(posedge CLOCK);
    RST_N <= 1'b1;
    cycles(3);
    chk("fast osc on", HS_OSC_EN, intl);
    chk("in pin gpio", IN_PIN_GPIO, intl);
  endtask : t_reset

  task automatic t_pins(input logic cko);
    logic last;
    int   k;
    int   n;
    chk("out pin gpio", OUT_PIN_GPIO, !cko);
    chk("out pin oe", OUT_PIN_OE, cko);
    last = OUT_PIN_O;
    k = 0;
    n = 0;
    for (int i = 0; i < 400 && cko && k < 3; i++) begin
      cycles(1);
      if (SYS_TICK === 1'b1) n++;
      if (OUT_PIN_O !== last) begin
        k++;
        if (k > 1) chk("clock out ticks", n, 4);
        n = 0;
        last = OUT_PIN_O;
      end
    end
  endtask : t_pins

  task automatic t_regs();
    int g;
    wr(REG_HS_FREQ, 8'h03);
    chk("freq", HS_FREQ, 4'h3);
    wr(REG_HS_TUNE, 8'h2a);
    chk("tune", HS_TUNE, 6'h2a);
    wr(REG_OSC_CTRL, {5'h0, OSC_LS});
    chk("switch req", SYS_SWITCH_REQ, 1'b1);
    chk("sys src", SYS_SRC, OSC_LS);
    cycles(1);
    chk("switch req end", SYS_SWITCH_REQ, 1'b0);
    chk("slow is internal", IN_PIN_GPIO, 1'b1);
    gap(2, g);
    chk("slow sys clock", g, 16);
    wr(REG_OSC_CTRL, 8'h16);
    chk("sys src back", SYS_SRC, OSC_HS_1M);
    gap(2, g);
    chk("post div 2", g, 8);
    wr(REG_OSC_CTRL, 8'hf6);
    gap(2, g);
    chk("post div 512", g, 2048);
    wr(REG_OSC_CTRL, 8'h06);
  endtask : t_regs

  task automatic t_status();
    logic [7:0] d;
    @(posedge CLOCK);
    {EXTERNAL_READY, HS_OSC_READY, LS_OSC_READY, SECONDARY_READY, ADC_OSC_OK, PLL_LOCK_READY} <= 6'h3b;
    cycles(4);
    rd(REG_OSC_STATUS, d);
    chk("status a", d, 8'hf5);
    @(posedge CLOCK);
    {EXTERNAL_READY, LS_OSC_READY, SECONDARY_READY, ADC_OSC_OK, PLL_LOCK_READY} <= 5'h04;
    cycles(4);
    wr(REG_OSC_STATUS, 8'hff);
    rd(REG_OSC_STATUS, d);
    chk("status b", d, 8'h68);
    wr(12'h0ab, 8'hff);
    rd(12'h0ab, d);
    chk("unmapped", d, 8'h00);
  endtask : t_status

  task automatic t_mf();
    int g;
    gap(0, g);
    chk("mf 500k code 3", g, 64);
    gap(1, g);
    chk("mf 31k code 3", g, 1024);
    wr(REG_HS_FREQ, 8'h00);
    gap(0, g);
    chk("mf 500k code 0", g, 8);
    for (int i = 0; i < 40 && LS_OSC_TICK !== 1'b1; i++) cycles(1);
    cycles(1);
    chk("slow timer tick", LS_TIMER_TICK, 1'b1);
    cycles(1);
    chk("slow timer idle", LS_TIMER_TICK, 1'b0);
  endtask : t_mf

  task automatic t_ref();
    int h;
    int r;
    wr(REG_REF_SRC, {5'h0, REF_SRC_HS});
    for (int d = 0; d < 8; d++) begin
      wr(REG_REF_CTRL, {3'h0, d[1:0], d[2:0]});
      wr(REG_REF_CTRL, {1'b1, 2'h0, d[1:0], d[2:0]});
      r = (d == 0) ? 4 : (2 << d) * d[1:0];
      for (int i = 0; i < 3000 && r > 0 && REF_CLK_OUT !== 1'b1; i++) cycles(1);
      h = 0;
      for (int i = 0; i < 3000 && r > 0 && REF_CLK_OUT === 1'b1; i++) begin
        h++;
        cycles(1);
      end
      chk("ref first pulse", h, r);
      count_high(1024, h);
      chk("ref high cycles", h, (d == 0) ? 512 : 256 * d[1:0]);
    end
    for (int i = 0; i < 3000 && REF_CLK_OUT !== 1'b1; i++) cycles(1);
    wr(REG_REF_CTRL, 8'h00);
    cycles(1);
    chk("ref stop", REF_CLK_OUT, 1'b0);
    count_high(200, h);
    chk("ref stays low", h, 0);
    for (int s = 0; s < 8; s++) begin
      wr(REG_REF_CTRL, 8'h00);
      wr(REG_REF_SRC, s[7:0]);
      wr(REG_REF_CTRL, 8'h80);
      count_high(2048, h);
      chk("ref source runs", h != 0, s < 5);
    end
    wr(REG_REF_CTRL, 8'h00);
  endtask : t_ref

  initial begin
    t_reset(OSC_HS_1M, 1'b0);
    t_pins(1'b0);
    t_regs();
    t_status();
    t_mf();
    t_ref();
    t_reset(OSC_HS_64M, 1'b1);
    t_pins(1'b1);
    t_reset(3'h2, 1'b0);
    end_sim();
  end

endmodule : osc_ref_clock_ctrl_tb_top
`default_nettype wire

// file: osc_ref_pkg.sv
// Shared constants for the internal oscillator control and reference clock output.
// Assumes a byte-wide register port with 12-bit addresses on a single 100 MHz clock.
package osc_ref_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [11:0] REG_OSC_CTRL   = 12'hed0;
  localparam logic [11:0] REG_HS_TUNE    = 12'hed2;
  localparam logic [11:0] REG_HS_FREQ    = 12'hed3;
  localparam logic [11:0] REG_OSC_STATUS = 12'hed6;
  localparam logic [11:0] REG_REF_CTRL   = 12'hed8;
  localparam logic [11:0] REG_REF_SRC    = 12'hed9;

  // Field positions.
  localparam int NEW_OSC_SELECT_LSB     = 0;
  localparam int HS_POST_PRESCALE_LSB     = 4;
  localparam int REF_DIV_LSB  = 0;
  localparam int REF_DUTY_LSB = 3;
  localparam int REF_EN_BIT   = 7;
  localparam int ST_EXT       = 7;
  localparam int ST_HS        = 6;
  localparam int ST_MF        = 5;
  localparam int ST_LS        = 4;
  localparam int ST_SEC       = 3;
  localparam int ST_ADC       = 2;
  localparam int ST_PLL       = 0;

  // System oscillator codes.
  localparam logic [2:0] OSC_HS_64M = 3'h0;
  localparam logic [2:0] OSC_LS     = 3'h5;
  localparam logic [2:0] OSC_HS_1M  = 3'h6;

  // Reference source codes.
  localparam logic [2:0] REF_SRC_SYS = 3'h0;
  localparam logic [2:0] REF_SRC_HS  = 3'h1;
  localparam logic [2:0] REF_SRC_LS  = 3'h2;
  localparam logic [2:0] REF_SRC_MF  = 3'h3;
  localparam logic [2:0] REF_SRC_SEC = 3'h4;

  // Reset values and counts.
  localparam logic [3:0] HS_FRQ_1M     = 4'h0;
  localparam logic [3:0] HS_FRQ_64M    = 4'h8;
  localparam logic [5:0] HS_TUNE_RST   = 6'h00;
  localparam logic [3:0] HS_POST_PRESCALE_RST      = 4'h0;
  localparam logic [3:0] HS_POST_PRESCALE_MAX      = 4'h9;
  localparam logic [7:0] REF_CTRL_RST  = 8'h00;
  localparam logic [2:0] REF_SRC_RST   = 3'h0;
  localparam logic [7:0] MF_LOW_RATIO  = 8'h10;
  localparam logic [1:0] CLKOUT_EDGES  = 2'h3;

  typedef enum logic [2:0] {
    REF_OFF = 3'b001,
    REF_ARM = 3'b010,
    REF_RUN = 3'b100
  } ref_state_t;

  // Edges of the fast oscillator per edge of the 500 kHz clock, per frequency code.
  function automatic logic [7:0] mf_ratio(input logic [3:0] code);
    case (code)
      4'h0:    mf_ratio = 8'h02;
      4'h1:    mf_ratio = 8'h04;
      4'h2:    mf_ratio = 8'h08;
      4'h3:    mf_ratio = 8'h10;
      4'h4:    mf_ratio = 8'h18;
      4'h5:    mf_ratio = 8'h20;
      4'h6:    mf_ratio = 8'h40;
      4'h7:    mf_ratio = 8'h60;
      default: mf_ratio = 8'h80;
    endcase
  endfunction : mf_ratio

endpackage : osc_ref_pkg

// file: ref_clock_out.sv
// Reference clock output generator: divider, duty cycle and glitch-free start.
// Assumes src_tick marks each edge of the chosen source, so one source period is two ticks.
`timescale 1ns/10ps
`default_nettype none
module ref_clock_out
  import osc_ref_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Settings
  input  wire logic       en,
  input  wire logic [2:0] div,
  input  wire logic [1:0] duty,
  input  wire logic       src_tick,
  // Output
  output logic            ref_out
);
  ref_state_t state_r;
  ref_state_t state_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       out_r;
  logic       out_nxt;
  logic [8:0] period;
  logic [8:0] high;
  logic [8:0] half;
  logic [8:0] cnt_inc;

  always_comb begin
    half    = 9'h001 << div;
    period  = half << 1;
    cnt_inc = {1'b0, cnt_r} + 9'h001;
    // The undivided setting is always square; duty only applies when divided.
    high      = (div == 3'h0) ? 9'h001 : 9'((half * {7'h00, duty}) >> 1);
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    out_nxt   = out_r;
    case (state_r)
      REF_OFF: begin
        out_nxt = 1'b0;
        cnt_nxt = 8'h00;
        if (en) begin
          state_nxt = REF_ARM;
        end
      end
      REF_ARM: begin
        // Start only on a source edge with a fresh period, so no runt pulse leaves.
        if (src_tick) begin
          state_nxt = REF_RUN;
          cnt_nxt   = 8'h00;
          out_nxt   = (high != 9'h000);
        end
      end
      REF_RUN: begin
        // Live divider and duty are used, so changing them while running may glitch.
        if (src_tick) begin
          cnt_nxt = (cnt_inc >= period) ? 8'h00 : cnt_inc[7:0];
          out_nxt = ({1'b0, cnt_nxt} < high);
        end
      end
      default: begin
        state_nxt = REF_OFF;
        out_nxt   = 1'b0;
      end
    endcase
    if (!en) begin
      state_nxt = REF_OFF;
      out_nxt   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= REF_OFF;
      cnt_r   <= 8'h00;
      out_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      out_r   <= out_nxt;
    end
  end

  assign ref_out = out_r;

  property p_ref_stop;
    @(posedge clk) disable iff (!rst_n) !en |=> !ref_out;
  endproperty
  a_ref_stop: assert property (p_ref_stop) else $error("reference output still driven after disable");

  property p_ref_start;
    @(posedge clk) disable iff (!rst_n) $rose(en) && state_r == REF_OFF |=> !ref_out && state_r == REF_ARM;
  endproperty
  a_ref_start: assert property (p_ref_start) else $error("reference output did not start cleanly");

  property p_ref_zero_duty;
    @(posedge clk) disable iff (!rst_n) en && div != 3'h0 && duty == 2'h0 && state_r == REF_RUN |=> !ref_out;
  endproperty
  a_ref_zero_duty: assert property (p_ref_zero_duty) else $error("zero duty produced a high level");

endmodule : ref_clock_out
`default_nettype wire

// file: tick_divider.sv
// Divides a stream of single-cycle edge ticks by a run-time divisor.
// Assumes ticks are one CLOCK cycle wide; a divisor of 0 or 1 passes every tick.
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Tick stream
  input  wire logic         tick_in,
  input  wire logic [W-1:0] divisor,
  output logic              tick_out
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         out_r;
  logic         out_nxt;
  logic [W:0]   cnt_inc;

  always_comb begin
    cnt_inc = {1'b0, cnt_r} + {{W{1'b0}}, 1'b1};
    cnt_nxt = cnt_r;
    out_nxt = 1'b0;
    if (tick_in) begin
      if (cnt_inc >= {1'b0, divisor}) begin
        cnt_nxt = '0;
        out_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_inc[W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign tick_out = out_r;

  property p_div_cause;
    @(posedge clk) disable iff (!rst_n) tick_out |-> $past(tick_in);
  endproperty
  a_div_cause: assert property (p_div_cause) else $error("divided tick without an input tick");

endmodule : tick_divider
`default_nettype wire
